// [rtl/lmm_cfg.svh]
`ifndef LMM_CFG_SVH
`define LMM_CFG_SVH

// apb register byte offsets
`define LMM_APB_AW        8
`define LMM_OFF_INSTR     8'h00
`define LMM_OFF_ACC       8'h04
`define LMM_OFF_BANK      8'h08
`define LMM_OFF_FLAGS     8'h0C
`define LMM_OFF_PROD      8'h10
`define LMM_OFF_PTR0      8'h14
`define LMM_OFF_PTR1      8'h18
`define LMM_OFF_PTR2      8'h1C
`define LMM_OFF_MADDR     8'h20
`define LMM_OFF_MDATA     8'h24
`define LMM_OFF_STATE     8'h28

// status flag bit positions
`define LMM_FLAG_C        0
`define LMM_FLAG_DC       1
`define LMM_FLAG_Z        2
`define LMM_FLAG_OV       3
`define LMM_FLAG_N        4

// data space
`define LMM_MEM_DEPTH     4096
`define LMM_ACCESS_HI     4'hF
`define LMM_ACCESS_LO     4'h0
`define LMM_ADDR_PCL      12'hFF9
`define LMM_ADDR_STACK_TOP_LOW     12'hFFD
`define LMM_ADDR_STACK_TOP_HIGH     12'hFFE
`define LMM_ADDR_STACK_TOP_UPPER     12'hFFF

// reset values
`define LMM_RST_BYTE      8'h00
`define LMM_RST_WORD      16'h0000

`endif

// [rtl/lmm_pkg.sv]
package lmm_pkg;

    typedef enum logic [1:0] {
        LMM_Q1 = 2'b00,
        LMM_Q2 = 2'b01,
        LMM_Q3 = 2'b10,
        LMM_Q4 = 2'b11
    } lmm_phase_t;

    typedef enum logic [1:0] {
        LMM_PEND_NONE = 2'b00,
        LMM_PEND_MOVE = 2'b01,
        LMM_PEND_PTR  = 2'b10
    } lmm_pend_t;

    typedef enum logic [3:0] {
        LMM_OP_IDLE    = 4'b0000,
        LMM_OP_OR_LIT  = 4'b0001,
        LMM_OP_OR_REG  = 4'b0010,
        LMM_OP_PTR1    = 4'b0011,
        LMM_OP_MOVE1   = 4'b0100,
        LMM_OP_WORD2   = 4'b0101,
        LMM_OP_BANK    = 4'b0110,
        LMM_OP_LIT     = 4'b0111,
        LMM_OP_STORE   = 4'b1000,
        LMM_OP_MUL_LIT = 4'b1001,
        LMM_OP_MUL_REG = 4'b1010,
        LMM_OP_NEG     = 4'b1011
    } lmm_op_t;

    typedef struct packed {
        logic       psel;
        logic       penable;
        logic       pwrite;
        logic [7:0] paddr;
        logic [31:0] pwdata;
    } lmm_apb_req_t;

    typedef struct packed {
        logic [31:0] prdata;
        logic        pready;
        logic        pslverr;
    } lmm_apb_rsp_t;

    typedef struct packed {
        logic            busy;
        lmm_phase_t      phase;
        lmm_pend_t       pend;
        logic [15:0]     ir;
        logic [7:0]      opnd;
        logic [7:0]      moveData;
        logic [7:0]      acc;
        logic [3:0]      bank;
        logic [4:0]      flags;
        logic [7:0]      product_high;
        logic [7:0]      product_low;
        logic [2:0][11:0] ptr;
        logic [11:0]     memAddr;
    } lmm_state_t;

endpackage : lmm_pkg

// [rtl/lmm_alu.sv]
`timescale 1ns/1ps
`include "lmm_cfg.svh"

// data path: or, two's complement negate and 8x8 unsigned multiply
module lmm_alu (
    input  wire lmm_pkg::lmm_op_t op,
    input  wire logic [7:0]       acc,
    input  wire logic [7:0]       opnd,
    input  wire logic [4:0]       flagsIn,
    output logic [7:0]            result,
    output logic [4:0]            flagsOut,
    output logic [15:0]           product
);
    logic [8:0] negSum;
    logic [4:0] lowSum;

    // result and flag update per operation
    always_comb
    begin
        negSum   = {1'b0, ~opnd} + 9'h001;
        lowSum   = {1'b0, ~opnd[3:0]} + 5'h01;
        product  = 16'(acc) * 16'(opnd);
        result   = opnd;
        flagsOut = flagsIn;
        unique case (op)
            lmm_pkg::LMM_OP_OR_LIT, lmm_pkg::LMM_OP_OR_REG:
            begin
                result = acc | opnd;
                flagsOut[`LMM_FLAG_N] = result[7];
                flagsOut[`LMM_FLAG_Z] = (result == 8'h00);
            end
            lmm_pkg::LMM_OP_NEG:
            begin
                result = negSum[7:0];
                flagsOut[`LMM_FLAG_N]  = result[7];
                flagsOut[`LMM_FLAG_Z]  = (result == 8'h00);
                flagsOut[`LMM_FLAG_C]  = negSum[8];
                flagsOut[`LMM_FLAG_DC] = lowSum[4];
                flagsOut[`LMM_FLAG_OV] = (opnd == 8'h80);
            end
            default:
            begin
                result   = opnd;
                flagsOut = flagsIn;
            end
        endcase
    end
endmodule : lmm_alu

// [rtl/lmm_regfile.sv]
`timescale 1ns/1ps
`include "lmm_cfg.svh"

// byte-wide data space in flip-flops, one write and one read port
module lmm_regfile #(
    parameter int DEPTH = `LMM_MEM_DEPTH
) (
    input  wire logic        clk,
    input  wire logic        nrst,
    input  wire logic        we,
    input  wire logic [11:0] waddr,
    input  wire logic [7:0]  wdata,
    input  wire logic [11:0] raddr,
    output logic [7:0]       rdata
);
    logic [7:0] mem [DEPTH];

    // read path, addresses wrap on the depth
    assign rdata = mem[raddr % DEPTH];

    // one storage cell per entry
    for (genvar i = 0; i < DEPTH; i++)
    begin : gCell
        always_ff @(posedge clk or negedge nrst)
        begin
            if (!nrst)
                mem[i] <= `LMM_RST_BYTE;
            else if (we && (waddr % DEPTH) == i)
                mem[i] <= wdata;
        end
    end
endmodule : lmm_regfile

// [rtl/lmm_exec.sv]
// The register offsets and the APB interface to the registers were chosen for this implementation.
`timescale 1ns/1ps
`include "lmm_cfg.svh"

// Summary of operation
// - or literal into accumulator, n and z
// - or register, d picks destination, n z
// - two-word pointer load, high then low
// - move: source word then destination word
// - move reads second phase, writes last phase
// - bank load takes low nibble, no flags
// - literal load into accumulator, no flags
// - store accumulator to file register
// - access bit zero selects access bank
// - literal multiply, unsigned, one cycle
// - product into high and low registers
// - multiply leaves all flags alone
// - negate register, updates five flags
module lmm_exec #(
    parameter int MEM_DEPTH = `LMM_MEM_DEPTH
) (
    input  wire logic                  clk,
    input  wire logic                  nrst,
    input  wire lmm_pkg::lmm_apb_req_t apbReq,
    output lmm_pkg::lmm_apb_rsp_t      apbRsp
);
    lmm_pkg::lmm_state_t s;
    lmm_pkg::lmm_state_t next_s;
    lmm_pkg::lmm_op_t    op;
    logic [7:0]  memRdata;
    logic [11:0] fileAddr;
    logic [11:0] rdAddr;
    logic [11:0] wrAddr;
    logic [7:0]  wrData;
    logic        memWe;
    logic        execWe;
    logic        access;
    logic        wrAcc;
    logic        unmapped;
    logic        atQ2;
    logic        atQ4;
    logic        startExec;
    logic        protDest;
    logic [7:0]  aluRes;
    logic [4:0]  aluFlags;
    logic [15:0] aluProd;
    logic [1:0]  ptrSel;

    // instruction decode from the held word
    always_comb
    begin
        op = lmm_pkg::LMM_OP_IDLE;
        if (s.ir[15:8] == 8'h09)
            op = lmm_pkg::LMM_OP_OR_LIT;
        else if (s.ir[15:10] == 6'b000100)
            op = lmm_pkg::LMM_OP_OR_REG;
        else if (s.ir[15:6] == 10'b1110111000)
            op = lmm_pkg::LMM_OP_PTR1;
        else if (s.ir[15:12] == 4'hC)
            op = lmm_pkg::LMM_OP_MOVE1;
        else if (s.ir[15:12] == 4'hF)
            op = lmm_pkg::LMM_OP_WORD2;
        else if (s.ir[15:4] == 12'h010)
            op = lmm_pkg::LMM_OP_BANK;
        else if (s.ir[15:8] == 8'h0E)
            op = lmm_pkg::LMM_OP_LIT;
        else if (s.ir[15:9] == 7'b0110111)
            op = lmm_pkg::LMM_OP_STORE;
        else if (s.ir[15:8] == 8'h0D)
            op = lmm_pkg::LMM_OP_MUL_LIT;
        else if (s.ir[15:9] == 7'b0000001)
            op = lmm_pkg::LMM_OP_MUL_REG;
        else if (s.ir[15:9] == 7'b0110110)
            op = lmm_pkg::LMM_OP_NEG;
    end

    // file address: access bank or bank select register
    always_comb
    begin
        if (s.ir[8])
            fileAddr = {s.bank, s.ir[7:0]};
        else if (s.ir[7])
            fileAddr = {`LMM_ACCESS_HI, s.ir[7:0]};
        else
            fileAddr = {`LMM_ACCESS_LO, s.ir[7:0]};
    end

    // bus and phase qualifiers
    assign access    = apbReq.psel && apbReq.penable;
    assign wrAcc     = access && apbReq.pwrite && !s.busy;
    assign startExec = wrAcc && apbReq.paddr == `LMM_OFF_INSTR;
    assign atQ2      = s.busy && s.phase == lmm_pkg::LMM_Q2;
    assign atQ4      = s.busy && s.phase == lmm_pkg::LMM_Q4;
    assign ptrSel    = s.ir[5:4];
    assign protDest  = s.ir[11:0] == `LMM_ADDR_PCL || s.ir[11:0] == `LMM_ADDR_STACK_TOP_UPPER
                    || s.ir[11:0] == `LMM_ADDR_STACK_TOP_HIGH || s.ir[11:0] == `LMM_ADDR_STACK_TOP_LOW;

    // read port: source word reads the full 12-bit space
    assign rdAddr = !s.busy ? s.memAddr
                  : (op == lmm_pkg::LMM_OP_MOVE1) ? s.ir[11:0] : fileAddr;

    // write port for the write phase or for the bus
    always_comb
    begin
        execWe = 1'b0;
        wrAddr = fileAddr;
        wrData = aluRes;
        if (atQ4)
        begin
            unique case (op)
                lmm_pkg::LMM_OP_OR_REG: execWe = s.ir[9];
                lmm_pkg::LMM_OP_NEG:    execWe = 1'b1;
                lmm_pkg::LMM_OP_STORE:
                begin
                    execWe = 1'b1;
                    wrData = s.acc;
                end
                lmm_pkg::LMM_OP_WORD2:
                begin
                    execWe = s.pend == lmm_pkg::LMM_PEND_MOVE && !protDest;
                    wrAddr = s.ir[11:0];
                    wrData = s.moveData;
                end
                default: execWe = 1'b0;
            endcase
        end
        memWe = execWe;
        if (!s.busy && wrAcc && apbReq.paddr == `LMM_OFF_MDATA)
        begin
            memWe  = 1'b1;
            wrAddr = s.memAddr;
            wrData = apbReq.pwdata[7:0];
        end
    end

    lmm_regfile #(
        .DEPTH (MEM_DEPTH)
    ) uRegfile (
        .clk   (clk),
        .nrst  (nrst),
        .we    (memWe),
        .waddr (wrAddr),
        .wdata (wrData),
        .raddr (rdAddr),
        .rdata (memRdata)
    );

    lmm_alu uAlu (
        .op       (op),
        .acc      (s.acc),
        .opnd     (s.opnd),
        .flagsIn  (s.flags),
        .result   (aluRes),
        .flagsOut (aluFlags),
        .product  (aluProd)
    );

    // next state: bus writes when idle, four phases per instruction word
    always_comb
    begin
        next_s = s;
        if (wrAcc)
        begin
            unique case (apbReq.paddr)
                `LMM_OFF_INSTR:
                begin
                    next_s.ir    = apbReq.pwdata[15:0];
                    next_s.busy  = 1'b1;
                    next_s.phase = lmm_pkg::LMM_Q1;
                end
                `LMM_OFF_ACC:   next_s.acc     = apbReq.pwdata[7:0];
                `LMM_OFF_BANK:  next_s.bank    = apbReq.pwdata[3:0];
                `LMM_OFF_FLAGS: next_s.flags   = apbReq.pwdata[4:0];
                `LMM_OFF_MADDR: next_s.memAddr = apbReq.pwdata[11:0];
                default:        next_s.memAddr = s.memAddr;
            endcase
        end
        if (s.busy)
        begin
            next_s.phase = lmm_pkg::lmm_phase_t'(s.phase + 2'b01);
            if (s.phase == lmm_pkg::LMM_Q2)
                next_s.opnd = (op == lmm_pkg::LMM_OP_OR_LIT || op == lmm_pkg::LMM_OP_LIT
                            || op == lmm_pkg::LMM_OP_MUL_LIT || op == lmm_pkg::LMM_OP_BANK
                            || op == lmm_pkg::LMM_OP_PTR1 || op == lmm_pkg::LMM_OP_WORD2)
                            ? s.ir[7:0] : memRdata;
            if (s.phase == lmm_pkg::LMM_Q4)
            begin
                next_s.busy = 1'b0;
                next_s.pend = lmm_pkg::LMM_PEND_NONE;
                unique case (op)
                    lmm_pkg::LMM_OP_OR_LIT:
                    begin
                        next_s.acc   = aluRes;
                        next_s.flags = aluFlags;
                    end
                    lmm_pkg::LMM_OP_OR_REG:
                    begin
                        if (!s.ir[9])
                            next_s.acc = aluRes;
                        next_s.flags = aluFlags;
                    end
                    lmm_pkg::LMM_OP_NEG:     next_s.flags = aluFlags;
                    lmm_pkg::LMM_OP_BANK:    next_s.bank = s.ir[3:0];
                    lmm_pkg::LMM_OP_LIT:     next_s.acc = s.opnd;
                    lmm_pkg::LMM_OP_MUL_LIT, lmm_pkg::LMM_OP_MUL_REG:
                    begin
                        next_s.product_high = aluProd[15:8];
                        next_s.product_low = aluProd[7:0];
                    end
                    lmm_pkg::LMM_OP_MOVE1:
                    begin
                        next_s.moveData = s.opnd;
                        next_s.pend     = lmm_pkg::LMM_PEND_MOVE;
                    end
                    lmm_pkg::LMM_OP_PTR1:
                    begin
                        if (ptrSel != 2'b11)
                        begin
                            next_s.ptr[ptrSel][11:8] = s.ir[3:0];
                            next_s.pend = lmm_pkg::LMM_PEND_PTR;
                        end
                    end
                    lmm_pkg::LMM_OP_WORD2:
                    begin
                        if (s.pend == lmm_pkg::LMM_PEND_PTR)
                            next_s.ptr[s.moveData[1:0]][7:0] = s.opnd;
                    end
                    default: next_s.pend = lmm_pkg::LMM_PEND_NONE;
                endcase
                if (op == lmm_pkg::LMM_OP_PTR1)
                    next_s.moveData = {6'h00, ptrSel};
            end
        end
    end

    // state register
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
            s <= '0;
        else
            s <= next_s;
    end

    // apb answer: wait states while an instruction word executes
    assign unmapped = apbReq.paddr > `LMM_OFF_STATE || apbReq.paddr[1:0] != 2'b00;
    always_comb
    begin
        apbRsp.pready  = !s.busy;
        apbRsp.pslverr = access && !s.busy && unmapped;
        apbRsp.prdata  = 32'h0000_0000;
        unique case (apbReq.paddr)
            `LMM_OFF_INSTR: apbRsp.prdata = {16'h0000, s.ir};
            `LMM_OFF_ACC:   apbRsp.prdata = {24'h000000, s.acc};
            `LMM_OFF_BANK:  apbRsp.prdata = {28'h0000000, s.bank};
            `LMM_OFF_FLAGS: apbRsp.prdata = {27'h0000000, s.flags};
            `LMM_OFF_PROD:  apbRsp.prdata = {16'h0000, s.product_high, s.product_low};
            `LMM_OFF_PTR0:  apbRsp.prdata = {20'h00000, s.ptr[0]};
            `LMM_OFF_PTR1:  apbRsp.prdata = {20'h00000, s.ptr[1]};
            `LMM_OFF_PTR2:  apbRsp.prdata = {20'h00000, s.ptr[2]};
            `LMM_OFF_MADDR: apbRsp.prdata = {20'h00000, s.memAddr};
            `LMM_OFF_MDATA: apbRsp.prdata = {24'h000000, memRdata};
            `LMM_OFF_STATE: apbRsp.prdata = {29'h00000000, s.pend, s.busy};
            default:        apbRsp.prdata = 32'h0000_0000;
        endcase
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);

    // checks on the execute path
    or_lit_result_a: assert property (atQ4 && op == lmm_pkg::LMM_OP_OR_LIT |=>
        s.acc == ($past(s.acc) | $past(s.ir[7:0])) && s.flags[3:0] == {$past(s.flags[3]),
        s.acc == 8'h00, $past(s.flags[1]), $past(s.flags[0])})
        else $error("or literal result wrong");
    or_reg_dest_a: assert property (atQ4 && op == lmm_pkg::LMM_OP_OR_REG && s.ir[9] |->
        memWe && wrData == (s.acc | s.opnd) ##1 $stable(s.acc))
        else $error("or register destination wrong");
    ptr_pending_a: assert property (atQ4 && op == lmm_pkg::LMM_OP_PTR1 && ptrSel != 2'b11 |=>
        s.pend == lmm_pkg::LMM_PEND_PTR && s.ptr[$past(ptrSel)][11:8] == $past(s.ir[3:0]))
        else $error("pointer high byte not loaded");
    move_source_a: assert property (atQ2 && op == lmm_pkg::LMM_OP_MOVE1 |->
        rdAddr == s.ir[11:0] ##3 s.pend == lmm_pkg::LMM_PEND_MOVE
        && s.moveData == $past(memRdata, 3))
        else $error("move source not captured");
    ptr_low_a: assert property (atQ4 && op == lmm_pkg::LMM_OP_WORD2
        && s.pend == lmm_pkg::LMM_PEND_PTR |=>
        s.ptr[$past(s.moveData[1:0])][7:0] == $past(s.ir[7:0]))
        else $error("pointer low byte not loaded");
    move_write_a: assert property (atQ4 && op == lmm_pkg::LMM_OP_WORD2
        && s.pend == lmm_pkg::LMM_PEND_MOVE && !protDest |->
        memWe && wrAddr == s.ir[11:0] && wrData == s.moveData)
        else $error("move destination not written");
    word_length_a: assert property (startExec |=> s.busy [*4] ##1 !s.busy)
        else $error("instruction word not four phases");
    bank_load_a: assert property (atQ4 && op == lmm_pkg::LMM_OP_BANK |=>
        s.bank == $past(s.ir[3:0]) && $stable(s.flags))
        else $error("bank select load wrong");
    lit_load_a: assert property (atQ4 && op == lmm_pkg::LMM_OP_LIT |=>
        s.acc == $past(s.ir[7:0]) && $stable(s.flags))
        else $error("literal load wrong");
    store_write_a: assert property (atQ4 && op == lmm_pkg::LMM_OP_STORE |->
        memWe && wrData == s.acc && wrAddr == fileAddr)
        else $error("accumulator store wrong");
    access_bank_a: assert property (atQ2 && op == lmm_pkg::LMM_OP_NEG && !s.ir[8] |->
        rdAddr[11:8] == (s.ir[7] ? `LMM_ACCESS_HI : `LMM_ACCESS_LO))
        else $error("access bank address wrong");
    mul_product_a: assert property (atQ4 && op == lmm_pkg::LMM_OP_MUL_LIT |=>
        {s.product_high, s.product_low} == 16'($past(s.acc)) * 16'($past(s.ir[7:0]))
        && $stable(s.acc) && $stable(s.flags))
        else $error("multiply product wrong");
    mul_reg_a: assert property (atQ4 && op == lmm_pkg::LMM_OP_MUL_REG |=>
        {s.product_high, s.product_low} == 16'($past(s.acc)) * 16'($past(s.opnd))
        && $stable(s.acc) && $stable(s.flags))
        else $error("register multiply wrong");
    neg_overflow_a: assert property (atQ4 && op == lmm_pkg::LMM_OP_NEG |=>
        s.flags[`LMM_FLAG_OV] == ($past(s.opnd) == 8'h80)
        && s.flags[`LMM_FLAG_N] == $past(~s.opnd[7] ^ (s.opnd[6:0] == 7'h00)))
        else $error("negate overflow or sign wrong");
    neg_zero_a: assert property (atQ4 && op == lmm_pkg::LMM_OP_NEG |=>
        s.flags[`LMM_FLAG_Z] == ($past(s.opnd) == 8'h00)
        && s.flags[`LMM_FLAG_C] == ($past(s.opnd) == 8'h00))
        else $error("negate flags wrong");
    move_protect_a: assert property (atQ4 && op == lmm_pkg::LMM_OP_WORD2
        && s.pend == lmm_pkg::LMM_PEND_MOVE && protDest |-> !memWe)
        else $error("protected move destination written");
    idle_quiet_a: assert property (atQ4 && op == lmm_pkg::LMM_OP_IDLE |->
        !memWe ##1 $stable(s.acc) && $stable(s.flags) && $stable(s.bank))
        else $error("idle word changed state");


    // main scenarios reached
    store_c:     cover property (atQ4 && op == lmm_pkg::LMM_OP_STORE && s.ir[8]);
    move_done_c: cover property (atQ4 && op == lmm_pkg::LMM_OP_WORD2
        && s.pend == lmm_pkg::LMM_PEND_MOVE);
    ptr_done_c:  cover property (atQ4 && op == lmm_pkg::LMM_OP_WORD2
        && s.pend == lmm_pkg::LMM_PEND_PTR);
    mul_c:       cover property (atQ4 && op == lmm_pkg::LMM_OP_MUL_REG);
    neg_c:       cover property (atQ4 && op == lmm_pkg::LMM_OP_NEG && s.opnd == 8'h80);
endmodule : lmm_exec

// [verif/literal_move_multiply_exec_bench.sv]
`timescale 1ns/1ps
`include "lmm_cfg.svh"

module literal_move_multiply_exec_bench;
    logic                  clk;
    logic                  nrst;
    lmm_pkg::lmm_apb_req_t apbReq;
    lmm_pkg::lmm_apb_rsp_t apbRsp;
    int                    failures;
    int                    check_count;
    logic                  lastErr;

    // 20 MHz clock
    initial clk = 1'b0;
    always #25 clk = ~clk;

    lmm_exec dut (
        .clk    (clk),
        .nrst   (nrst),
        .apbReq (apbReq),
        .apbRsp (apbRsp)
    );

    // verdict and end of run
    task automatic conclude;
        $display("checks %0d mismatches %0d", check_count, failures);
        if (failures == 0 && check_count > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask : conclude

    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        check_count++;
        if (got !== exp)
        begin
            $display("unexpected %s: expected %0h seen %0h", what, exp, got);
            failures++;
        end
    endtask : check

    // one apb transfer; waits for pready with a bounded loop
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] q);
        int n;
        @(posedge clk);
        apbReq <= '{1'b1, 1'b0, wr, a, d};
        @(posedge clk);
        apbReq.penable <= 1'b1;
        n = 0;
        do
        begin
            @(posedge clk);
            n++;
        end
        while (apbRsp.pready !== 1'b1 && n < 40);
        // answer taken at the rising edge that completes the access
        q = apbRsp.prdata;
        lastErr = apbRsp.pslverr;
        apbReq <= '0;
        if (n >= 40)
        begin
            failures++;
            conclude();
        end
    endtask : apb

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        apb(1'b1, a, d, q);
    endtask : wr

    task automatic rd(input logic [7:0] a, input logic [31:0] exp, input string what);
        logic [31:0] q;
        apb(1'b0, a, 32'h0, q);
        check(what, exp, q);
    endtask : rd

    task automatic ins(input logic [15:0] w);
        wr(`LMM_OFF_INSTR, {16'h0, w});
    endtask : ins

    task automatic poke(input logic [11:0] a, input logic [7:0] d);
        wr(`LMM_OFF_MADDR, {20'h0, a});
        wr(`LMM_OFF_MDATA, {24'h0, d});
    endtask : poke

    task automatic mem(input logic [11:0] a, input logic [7:0] exp, input string what);
        wr(`LMM_OFF_MADDR, {20'h0, a});
        rd(`LMM_OFF_MDATA, {24'h0, exp}, what);
    endtask : mem

    // reset values and an unmapped address
    task automatic t_reset;
        rd(`LMM_OFF_ACC, 32'h0, "acc reset");
        rd(`LMM_OFF_FLAGS, 32'h0, "flags reset");
        rd(`LMM_OFF_PROD, 32'h0, "product reset");
        rd(8'h2C, 32'h0, "unmapped data");
        check("unmapped error", 32'h1, {31'h0, lastErr});
        $display("test reset done");
    endtask : t_reset

    // or literal, then literal load keeps flags, zero result sets z
    task automatic t_or_lit;
        wr(`LMM_OFF_ACC, 32'h9A);
        wr(`LMM_OFF_FLAGS, 32'h0B);
        ins(16'h0935);
        rd(`LMM_OFF_ACC, 32'hBF, "or literal acc");
        rd(`LMM_OFF_FLAGS, 32'h1B, "or literal flags");
        ins(16'h0E00);
        rd(`LMM_OFF_FLAGS, 32'h1B, "literal load flags");
        ins(16'h0900);
        rd(`LMM_OFF_FLAGS, 32'h0F, "or zero flags");
        ins(16'h0E5A);
        rd(`LMM_OFF_ACC, 32'h5A, "literal load acc");
        $display("test or literal done");
    endtask : t_or_lit

    // bank load and stores through both access bit settings
    task automatic t_store;
        wr(`LMM_OFF_FLAGS, 32'h15);
        ins(16'h0105);
        rd(`LMM_OFF_BANK, 32'h5, "bank");
        ins(16'h0E4F);
        ins(16'h6F20);
        ins(16'h6E90);
        ins(16'h6E10);
        mem(12'h520, 8'h4F, "banked store");
        mem(12'hF90, 8'h4F, "access high store");
        mem(12'h010, 8'h4F, "access low store");
        mem(12'h510, 8'h00, "bank ignored");
        rd(`LMM_OFF_FLAGS, 32'h15, "store flags");
        $display("test store done");
    endtask : t_store

    // or with register, both destinations
    task automatic t_or_reg;
        wr(`LMM_OFF_ACC, 32'h30);
        wr(`LMM_OFF_FLAGS, 32'h1F);
        ins(16'h1320);
        mem(12'h520, 8'h7F, "or to register");
        rd(`LMM_OFF_ACC, 32'h30, "acc kept");
        rd(`LMM_OFF_FLAGS, 32'h0B, "or register flags");
        wr(`LMM_OFF_ACC, 32'h80);
        ins(16'h1120);
        rd(`LMM_OFF_ACC, 32'hFF, "or to acc");
        rd(`LMM_OFF_FLAGS, 32'h1B, "or acc flags");
        $display("test or register done");
    endtask : t_or_reg

    // literal multiply keeps acc and flags
    task automatic t_mul;
        wr(`LMM_OFF_ACC, 32'hE2);
        wr(`LMM_OFF_FLAGS, 32'h15);
        ins(16'h0DC4);
        rd(`LMM_OFF_PROD, 32'hAD08, "product");
        rd(`LMM_OFF_ACC, 32'hE2, "mul acc");
        rd(`LMM_OFF_FLAGS, 32'h15, "mul flags");
        ins(16'h0D00);
        rd(`LMM_OFF_PROD, 32'h0, "zero product");
        rd(`LMM_OFF_FLAGS, 32'h15, "zero product flags");
        // register multiply, banked operand at 0x520 holds 0x7F
        ins(16'h0320);
        rd(`LMM_OFF_PROD, 32'h701E, "register product");
        rd(`LMM_OFF_FLAGS, 32'h15, "register product flags");
        $display("test multiply done");
    endtask : t_mul

    // negate rewrites all five flags
    task automatic t_neg;
        poke(12'h030, 8'h3A);
        wr(`LMM_OFF_FLAGS, 32'h0F);
        ins(16'h6C30);
        mem(12'h030, 8'hC6, "negate");
        rd(`LMM_OFF_FLAGS, 32'h10, "negate flags");
        // most negative value: overflow, sign and digit carry set
        poke(12'h030, 8'h80);
        ins(16'h6C30);
        mem(12'h030, 8'h80, "negate 0x80");
        rd(`LMM_OFF_FLAGS, 32'h1A, "negate 0x80 flags");
        $display("test negate done");
    endtask : t_neg

    // two-word pointer loads
    task automatic t_ptr;
        ins(16'hEE23);
        rd(`LMM_OFF_STATE, 32'h4, "pointer pending");
        ins(16'hF0AB);
        rd(`LMM_OFF_PTR2, 32'h3AB, "pointer two");
        ins(16'hEE0F);
        ins(16'hF0FF);
        rd(`LMM_OFF_PTR0, 32'hFFF, "pointer zero");
        $display("test pointer done");
    endtask : t_ptr

    // two-word move, then a refused destination
    task automatic t_move;
        poke(12'h000, 8'h5A);
        ins(16'hC000);
        rd(`LMM_OFF_STATE, 32'h2, "move pending");
        ins(16'hFFFC);
        mem(12'hFFC, 8'h5A, "move");
        mem(12'h000, 8'h5A, "move source");
        ins(16'hC000);
        ins(16'hFFF9);
        mem(12'hFF9, 8'h00, "counter low untouched");
        $display("test move done");
    endtask : t_move

    // idle words change nothing
    task automatic t_idle;
        wr(`LMM_OFF_ACC, 32'h66);
        wr(`LMM_OFF_FLAGS, 32'h09);
        ins(16'hF123);
        ins(16'h0000);
        rd(`LMM_OFF_ACC, 32'h66, "idle acc");
        rd(`LMM_OFF_FLAGS, 32'h09, "idle flags");
        rd(`LMM_OFF_STATE, 32'h0, "idle state");
        $display("test idle done");
    endtask : t_idle

    // main sequence
    initial
    begin
        nrst = 1'b0;
        apbReq = '0;
        failures = 0;
        check_count = 0;
        lastErr = 1'b0;
        repeat (5) @(posedge clk);
        nrst <= 1'b1;
        t_reset();
        t_or_lit();
        t_store();
        t_or_reg();
        t_mul();
        t_neg();
        t_ptr();
        t_move();
        t_idle();
        conclude();
    end
endmodule : literal_move_multiply_exec_bench
